/* src/scc_top.sv */
// Purpose: Commutation and braking control of a three-phase spindle bridge
// Assumes: Pins are asynchronous to hclk, torque voltages arrive as 8-bit codes
// Notes:   Switch and phase outputs are registered, three cycles after a Hall pin change, four after any other pin change
//
// What this block does
// R1 - Run high and awake: commutate phases from Hall code and PWM.
// R2 - Run low: ignore Hall and PWM, all high sides on, low sides off.
// R3 - Hall code picks source and sink phase; conduction only while PWM high.
// R4 - Source high side stays on; sink low side follows PWM.
// R5 - Normal variant: sink high side off during PWM off time.
// R6 - Synchronous variant: sink high side on, complementary, during PWM off.
// R7 - Reference above command: forward drive, duty proportional to difference.
// R8 - Command above reference: reverse brake, driving the motor backward.
// R9 - Reverse rotation seen during reverse brake: stop driving.
// R10 - Equal voltages: short brake.
// R11 - Standby input high runs; low enters standby with internal supply off.
// R12 - Standby puts all three phase outputs into high impedance.
// R13 - Standby halts the PWM oscillator.
// R14 - Run/stop only acts while the oscillator runs, outside standby.
// R15 - Output bits 0, 1, 2 are phases U, V, W; Hall code bits 2, 1, 0 are U, V, W.
// R16 - Reverse rotation comes from Hall steps running against forward order.
// R17 - Hall codes all high or all low switch every switch off in forward and reverse drive.
// R18 - A configuration bit selects normal or synchronous off-time switching.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module scc_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        run_stop_in,
    input  wire logic        standby_n_in,
    input  wire logic        hall_cmp_u,
    input  wire logic        hall_cmp_v,
    input  wire logic        hall_cmp_w,
    input  wire logic [7:0]  torque_cmd_voltage,
    input  wire logic [7:0]  torque_ref_voltage,
    output logic [2:0]       high_side_on,
    output logic [2:0]       low_side_on,
    output logic             phase_u_out,
    output logic             phase_v_out,
    output logic             phase_w_out,
    output logic             phase_u_oe_n,
    output logic             phase_v_oe_n,
    output logic             phase_w_oe_n,
    output logic             supply_on
);
    import scc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoding functions

    // Position of a Hall code along the forward commutation order
    function automatic logic [2:0] hall_step(input logic [2:0] code);
        case (code)
            3'h6:    hall_step = 3'h0;
            3'h4:    hall_step = 3'h1;
            3'h5:    hall_step = 3'h2;
            3'h1:    hall_step = 3'h3;
            3'h3:    hall_step = 3'h4;
            3'h2:    hall_step = 3'h5;
            default: hall_step = STEP_NONE;
        endcase
    endfunction : hall_step

    // Source phase in bits 3:2, sink phase in bits 1:0
    function automatic logic [3:0] step_phases(input logic [2:0] step);
        case (step)
            3'h0:    step_phases = {PH_W, PH_V};
            3'h1:    step_phases = {PH_W, PH_U};
            3'h2:    step_phases = {PH_V, PH_U};
            3'h3:    step_phases = {PH_V, PH_W};
            3'h4:    step_phases = {PH_U, PH_W};
            3'h5:    step_phases = {PH_U, PH_V};
            default: step_phases = {PH_U, PH_U};
        endcase
    endfunction : step_phases

    function automatic logic [2:0] step_inc(input logic [2:0] step);
        step_inc = (step == STEP_LAST) ? 3'h0 : step + 3'h1;
    endfunction : step_inc

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; torque codes are assumed to change slowly
    localparam int unsigned PIN_W = 21;

    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic             run_sync;
    logic             stb_sync;
    logic [2:0]       hall_sync;
    logic [7:0]       cmd_sync;
    logic [7:0]       ref_sync;

    // Only the second stage is read by logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {run_stop_in, standby_n_in, hall_cmp_u, hall_cmp_v, hall_cmp_w,
                           torque_cmd_voltage, torque_ref_voltage};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign run_sync  = pin_sync_r[20];
    assign stb_sync  = pin_sync_r[19];
    assign hall_sync = pin_sync_r[18:16]; // see R15
    assign cmd_sync  = pin_sync_r[15:8];
    assign ref_sync  = pin_sync_r[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Torque difference and PWM oscillator
    logic signed [8:0] diff;
    logic [7:0]        duty;
    logic              pwm;
    logic [7:0]        osc_count;

    assign diff = $signed({1'b0, ref_sync}) - $signed({1'b0, cmd_sync});
    assign duty = diff[8] ? 8'(~diff[7:0] + 8'h01) : diff[7:0]; // see R7

    scc_pwm_osc u_osc (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .osc_run   (stb_sync),
        .duty      (duty),
        .pwm_out   (pwm),
        .osc_count (osc_count)
    );

    assign supply_on = stb_sync; // see R11

    ////////////////////////////////////////////////////////////////////////
    // Rotation direction from the order of Hall steps
    logic [2:0] step_now;
    logic [2:0] prev_step_r;
    logic       rev_seen_r;

    assign step_now = hall_step(hall_sync);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_step_r <= STEP_NONE;
        end else if (step_now != STEP_NONE) begin
            prev_step_r <= step_now;
        end
    end

    // A skipped step keeps the last verdict rather than guessing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rev_seen_r <= 1'b0;
        end else if (step_now != STEP_NONE && prev_step_r != STEP_NONE) begin
            if (step_inc(step_now) == prev_step_r) begin
                rev_seen_r <= 1'b1; // see R16
            end else if (step_inc(prev_step_r) == step_now) begin
                rev_seen_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operating mode
    scc_mode_e mode_r;
    scc_mode_e mode_nxt;

    // Standby outranks run/stop, run/stop outranks the torque order
    always_comb begin
        if (!stb_sync) begin
            mode_nxt = SCC_STANDBY; // see R11
        end else if (!run_sync) begin
            mode_nxt = SCC_STOP; // see R2 see R14
        end else if (diff == 9'sh000) begin
            mode_nxt = SCC_BRAKE; // see R10
        end else if (!diff[8]) begin
            mode_nxt = SCC_FWD; // see R1 see R7
        end else if (rev_seen_r || mode_r == SCC_REV_DONE) begin
            mode_nxt = SCC_REV_DONE; // see R9
        end else begin
            mode_nxt = SCC_REV; // see R8
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= SCC_STANDBY;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bridge switch selection
    logic       sync_pwm;
    logic [3:0] phases;
    logic [1:0] src;
    logic [1:0] snk;
    logic [2:0] hs_nxt;
    logic [2:0] ls_nxt;
    logic [2:0] hs_r;
    logic [2:0] ls_r;

    assign phases = step_phases(step_now);
    assign src    = (mode_r == SCC_REV) ? phases[1:0] : phases[3:2]; // see R8
    assign snk    = (mode_r == SCC_REV) ? phases[3:2] : phases[1:0];

    always_comb begin
        hs_nxt = 3'h0;
        ls_nxt = 3'h0;
        case (mode_r)
            SCC_STOP, SCC_BRAKE, SCC_REV_DONE: begin
                hs_nxt = 3'h7; // see R2 see R10
            end
            SCC_FWD, SCC_REV: begin
                if (step_now != STEP_NONE) begin // see R17
                    hs_nxt[src] = 1'b1; // see R3 see R4
                    if (pwm) begin
                        ls_nxt[snk] = 1'b1; // see R1 see R3
                    end else if (sync_pwm) begin // see R5, sink high side stays off otherwise
                        hs_nxt[snk] = 1'b1; // see R6
                    end
                end
            end
            default: begin
                hs_nxt = 3'h0; // see R12
            end
        endcase
    end

    // Registered drive; high and low side of one leg are never both chosen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_r <= 3'h0;
            ls_r <= 3'h0;
        end else begin
            hs_r <= hs_nxt;
            ls_r <= ls_nxt;
        end
    end

    assign high_side_on = hs_r;
    assign low_side_on  = ls_r;
    assign phase_u_out  = hs_r[PH_U];
    assign phase_v_out  = hs_r[PH_V];
    assign phase_w_out  = hs_r[PH_W];
    // A leg with neither switch on floats
    assign phase_u_oe_n = !(hs_r[PH_U] || ls_r[PH_U]); // see R12
    assign phase_v_oe_n = !(hs_r[PH_V] || ls_r[PH_V]);
    assign phase_w_oe_n = !(hs_r[PH_W] || ls_r[PH_W]);

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    logic [31:0] ctrl_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] rdata_r;
    logic        take;
    logic [31:0] status;

    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign sync_pwm  = ctrl_r[CTRL_SYNC_BIT]; // see R18
    assign status    = {18'h0, ls_r, hs_r, pwm, rev_seen_r, 3'(mode_r), hall_sync};

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    // Data phase write; unmapped addresses are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_pend_r && wr_addr_r == ADDR_CTRL) begin
            ctrl_r <= {31'h0, hwdata[CTRL_SYNC_BIT]};
        end
    end

    // Read data prepared at the address phase so it stands registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                ADDR_CTRL:   rdata_r <= ctrl_r;
                ADDR_STATUS: rdata_r <= status;
                default:     rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_standby_hiz: assert property (!stb_sync |-> ##2 (phase_u_oe_n && phase_v_oe_n && phase_w_oe_n)) // see R12
        else $error("phase outputs driven in standby");
    a_osc_frozen: assert property (!stb_sync |=> $stable(osc_count) && !pwm) // see R13
        else $error("oscillator ran in standby");
    a_stop_brake: assert property (stb_sync && !run_sync |-> ##2 (hs_r == 3'h7 && ls_r == 3'h0)) // see R2
        else $error("stop did not give short brake");
    a_equal_brake: assert property (stb_sync && run_sync && diff == 9'sh000 |=> mode_r == SCC_BRAKE) // see R10
        else $error("equal torque voltages not braking");
    a_no_shoot: assert property ((hs_r & ls_r) == 3'h0) // see R4
        else $error("both switches of one leg on");
    a_pwm_on_sink: assert property ((mode_r == SCC_FWD || mode_r == SCC_REV) && step_now != STEP_NONE && pwm
                                    |=> $countones(ls_r) == 1 && $countones(hs_r) == 1) // see R3
        else $error("pwm on time without one source and one sink");
    a_normal_off: assert property (mode_r == SCC_FWD && !pwm && !sync_pwm && step_now != STEP_NONE
                                   |=> ls_r == 3'h0 && $countones(hs_r) == 1) // see R5
        else $error("normal variant switched sink high side");
    a_sync_off: assert property (mode_r == SCC_FWD && !pwm && sync_pwm && step_now != STEP_NONE
                                 |=> ls_r == 3'h0 && $countones(hs_r) == 2) // see R6
        else $error("synchronous variant missed complement");
    a_invalid_off: assert property (mode_r == SCC_FWD && step_now == STEP_NONE |=> hs_r == 3'h0 && ls_r == 3'h0) // see R17
        else $error("invalid hall code left a switch on");
    a_rev_stop: assert property (stb_sync && run_sync && diff[8] && rev_seen_r |=> mode_r == SCC_REV_DONE) // see R9
        else $error("reverse drive kept after reverse seen");

endmodule : scc_top
`default_nettype wire

/* inc/scc_pkg.sv */
// Purpose: Shared constants and types of the spindle commutation controller
// Assumes: 125 MHz hclk, AHB-Lite register access with 32-bit words
// Notes:   Phase index 0, 1, 2 stands for motor phase U, V, W; Hall codes are packed {u,v,w}, U in bit 2
package scc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and PWM oscillator timing
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned PWM_FREQ_HZ  = 75_000;
    localparam int unsigned PWM_STEPS    = 255;
    // Longest step period rounds down, never below one cycle
    localparam int unsigned OSC_DIV_RAW  = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
    localparam int unsigned OSC_DIV      = (OSC_DIV_RAW < 1) ? 1 : OSC_DIV_RAW;
    localparam logic [7:0]  OSC_DIV_LAST = 8'(OSC_DIV - 1);
    localparam logic [7:0]  PWM_CNT_LAST = 8'(PWM_STEPS - 1);

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam int unsigned CTRL_SYNC_BIT   = 0;
    localparam int unsigned STAT_HALL_LSB   = 0;
    localparam int unsigned STAT_MODE_LSB   = 3;
    localparam int unsigned STAT_REV_BIT    = 6;
    localparam int unsigned STAT_PWM_BIT    = 7;
    localparam int unsigned STAT_HS_LSB     = 8;
    localparam int unsigned STAT_LS_LSB     = 11;

    ////////////////////////////////////////////////////////////////////////
    // Phase indexes and step numbers along the forward order
    localparam logic [2:0]  STEP_NONE    = 3'h7;
    localparam logic [2:0]  STEP_LAST    = 3'h5;
    localparam logic [1:0]  PH_U         = 2'h0;
    localparam logic [1:0]  PH_V         = 2'h1;
    localparam logic [1:0]  PH_W         = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Operating modes, Gray steps from standby toward reverse drive
    typedef enum logic [2:0] {
        SCC_STANDBY  = 3'h0,
        SCC_STOP     = 3'h1,
        SCC_FWD      = 3'h3,
        SCC_BRAKE    = 3'h2,
        SCC_REV      = 3'h6,
        SCC_REV_DONE = 3'h7
    } scc_mode_e;

endpackage : scc_pkg

/* src/scc_pwm_osc.sv */
// Purpose: PWM oscillator, sawtooth counter compared with the duty value
// Assumes: duty comes from logic on hclk
// Notes:   Counter freezes while osc_run is low, saving switching power
`timescale 1ns/1ps
`default_nettype none
module scc_pwm_osc (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       osc_run,
    input  wire logic [7:0] duty,
    output logic            pwm_out,
    output logic [7:0]      osc_count
);
    import scc_pkg::*;

    logic [7:0] div_r;
    logic       tick;

    ////////////////////////////////////////////////////////////////////////
    // Step divider, one-cycle enable pulse
    assign tick = osc_run && (div_r == OSC_DIV_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 8'h00;
        end else if (!osc_run || tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Sawtooth of PWM_STEPS steps so that duty 8'hFF means always on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_count <= 8'h00;
        end else if (tick) begin // see R13
            osc_count <= (osc_count == PWM_CNT_LAST) ? 8'h00 : osc_count + 8'h01;
        end
    end

    // Duty proportional to magnitude of the torque difference
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= osc_run && (osc_count < duty); // see R7
        end
    end

endmodule : scc_pwm_osc
`default_nettype wire

/* verification/scc_hall_model.sv */
// Purpose: Hall sensor model, comparator levels of a turning rotor
// Assumes: one step pulse per sector, on hclk
// Notes:   A forced code stands in for a broken or unplugged sensor
`timescale 1ns/1ps
`default_nettype none
module scc_hall_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       step_fwd,
    input  wire logic       step_rev,
    input  wire logic       bad_en,
    input  wire logic [2:0] bad_code,
    output logic            hall_cmp_u,
    output logic            hall_cmp_v,
    output logic            hall_cmp_w
);
    logic [2:0] pos_r;
    logic [2:0] code;
    ////////////////////////////////////////////////////////////////////////
    // Rotor moves one sector per pulse, wrapping after six sectors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_r <= 3'h0;
        end else if (step_fwd) begin
            pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
        end else if (step_rev) begin
            pos_r <= (pos_r == 3'h0) ? 3'h5 : pos_r - 3'h1;
        end
    end
    // Sector to code {u,v,w}; a forced code overrides, like a dead sensor would
    always_comb begin
        case (pos_r)
            3'h0: code = 3'h6;
            3'h1: code = 3'h4;
            3'h2: code = 3'h5;
            3'h3: code = 3'h1;
            3'h4: code = 3'h3;
            default: code = 3'h2;
        endcase
        if (bad_en) begin
            code = bad_code;
        end
    end
    assign {hall_cmp_u, hall_cmp_v, hall_cmp_w} = code;
endmodule : scc_hall_model
`default_nettype wire

/* verification/tb.sv */
// Purpose: Self-checking bench of the spindle commutation controller
// Assumes: zero-wait register slave, pins settle within ten cycles
// Notes:   Bridge and supply outputs are sampled on the falling edge, away from updates; bus outputs just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scc_pkg::*;
    localparam logic [2:0] SRC [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
    localparam logic [2:0] SNK [6] = '{3'h2, 3'h1, 3'h1, 3'h4, 3'h4, 3'h2};
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, st;
    logic [1:0]  htrans;
    logic [2:0]  hsize, high_side_on, low_side_on, bad_code;
    logic        run_stop_in, standby_n_in, hall_cmp_u, hall_cmp_v, hall_cmp_w;
    logic [7:0]  torque_cmd_voltage, torque_ref_voltage;
    logic        phase_u_out, phase_v_out, phase_w_out, supply_on;
    logic        phase_u_oe_n, phase_v_oe_n, phase_w_oe_n;
    logic        step_fwd, step_rev, bad_en;
    int          n_mismatch, checked, k, cnt;
    assign hready = hreadyout;
    ////////////////////////////////////////////////////////////////////////
    // Design and the Hall sensors that feed it
    scc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .run_stop_in(run_stop_in), .standby_n_in(standby_n_in),
        .hall_cmp_u(hall_cmp_u), .hall_cmp_v(hall_cmp_v), .hall_cmp_w(hall_cmp_w),
        .torque_cmd_voltage(torque_cmd_voltage), .torque_ref_voltage(torque_ref_voltage),
        .high_side_on(high_side_on), .low_side_on(low_side_on), .phase_u_out(phase_u_out),
        .phase_v_out(phase_v_out), .phase_w_out(phase_w_out), .phase_u_oe_n(phase_u_oe_n),
        .phase_v_oe_n(phase_v_oe_n), .phase_w_oe_n(phase_w_oe_n), .supply_on(supply_on));
    scc_hall_model hall_u (.hclk(hclk), .hresetn(hresetn), .step_fwd(step_fwd), .step_rev(step_rev),
        .bad_en(bad_en), .bad_code(bad_code), .hall_cmp_u(hall_cmp_u), .hall_cmp_v(hall_cmp_v),
        .hall_cmp_w(hall_cmp_w));
    ////////////////////////////////////////////////////////////////////////
    // Clock, 8 ns period
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // Verdict and end of run, the only exit
    task automatic test_done;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk32
    // Switch gates, driven levels and leg enables must all agree
    task automatic chk_bridge(input logic [2:0] hi, input logic [2:0] lo);
        chk32({26'h0, high_side_on, low_side_on}, {26'h0, hi, lo}, "switches");
        chk32({29'h0, phase_w_out, phase_v_out, phase_u_out}, {29'h0, hi}, "phase level");
        chk32({29'h0, phase_w_oe_n, phase_v_oe_n, phase_u_oe_n}, {29'h0, ~(hi | lo)}, "enable");
    endtask : chk_bridge
    // Fixed wait covers the pin synchronisers and output registers
    task automatic settle;
        repeat (10) @(posedge hclk);
        @(negedge hclk);
    endtask : settle
    // Bounded wait on the bus; running out ends the run as a failure
    task automatic wait_rdy;
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hready === 1'b1) return;
        end
        n_mismatch++;
        $display("MISMATCH t=%0t bus hang", $time);
        test_done();
    endtask : wait_rdy
    // One single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb
    // Wait for the PWM on or off part, bounded by 4000 cycles, about two and a half periods
    task automatic wait_pwm(input logic on);
        for (int i = 0; i < 4000; i++) begin
            @(negedge hclk);
            if ((low_side_on !== 3'h0) == on) return;
        end
        n_mismatch++;
        $display("MISMATCH t=%0t pwm stuck", $time);
        test_done();
    endtask : wait_pwm
    task automatic step(input logic fwd);
        @(posedge hclk);
        step_fwd <= fwd;
        step_rev <= !fwd;
        @(posedge hclk);
        step_fwd <= 1'b0;
        step_rev <= 1'b0;
    endtask : step
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_mismatch = 0;
        checked = 0;
        {hresetn, hsel, hwrite, run_stop_in, standby_n_in, step_fwd, step_rev, bad_en} = '0;
        {haddr, hwdata, htrans, bad_code, torque_cmd_voltage, torque_ref_voltage} = '0;
        hsize = 3'h2;
        repeat (7) @(posedge hclk);
        @(negedge hclk);
        chk_bridge(3'h0, 3'h0);
        // Release on a rising edge, like every other bench input
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0, st);
        chk32(st, CTRL_RESET, "ctrl reset");
        ahb(1'b1, 32'h8, 32'hFFFF_FFFF, st);
        ahb(1'b0, 32'h8, 32'h0, st);
        chk32(st, 32'h0, "unmapped");
        chk32({31'h0, hresp}, 32'h0, "hresp");
        // Standby: run pin ignored, legs floating, oscillator halted
        run_stop_in <= 1'b1;
        settle();
        chk_bridge(3'h0, 3'h0);
        chk32({31'h0, supply_on}, 32'h0, "supply");
        ahb(1'b0, 32'h4, 32'h0, st);
        chk32(st & 32'hF8, 32'h0, "standby status");
        // Awake but stopped: short brake whatever the Hall code
        @(posedge hclk);
        standby_n_in <= 1'b1;
        run_stop_in <= 1'b0;
        torque_ref_voltage <= 8'hFF;
        settle();
        chk_bridge(3'h7, 3'h0);
        chk32({31'h0, supply_on}, 32'h1, "supply");
        // Full duty forward around all six sectors
        @(posedge hclk);
        run_stop_in <= 1'b1;
        for (k = 0; k < 6; k++) begin
            settle();
            chk_bridge(SRC[k], SNK[k]);
            if (k == 0) begin
                ahb(1'b0, 32'h4, 32'h0, st);
                chk32(st & 32'h3F, 32'h1E, "fwd status");
            end
            step(1'b1);
        end
        // Duty proportional to the voltage difference
        @(posedge hclk);
        torque_ref_voltage <= 8'd100;
        torque_cmd_voltage <= 8'd36;
        settle();
        cnt = 0;
        repeat (OSC_DIV * PWM_STEPS) begin
            @(negedge hclk);
            if (low_side_on !== 3'h0) cnt++;
        end
        chk32(cnt, 64 * OSC_DIV, "on time");
        wait_pwm(1'b1);
        chk_bridge(SRC[0], SNK[0]);
        wait_pwm(1'b0);
        chk_bridge(SRC[0], 3'h0);
        ahb(1'b1, 32'h0, 32'hFFFF_FFFF, st);
        ahb(1'b0, 32'h0, 32'h0, st);
        chk32(st, 32'h1, "ctrl");
        settle();
        wait_pwm(1'b1);
        wait_pwm(1'b0);
        chk_bridge(SRC[0] | SNK[0], 3'h0);
        // Invalid codes, then equal voltages
        @(posedge hclk);
        torque_ref_voltage <= 8'hFF;
        torque_cmd_voltage <= 8'h00;
        bad_en <= 1'b1;
        for (k = 0; k < 2; k++) begin
            @(posedge hclk);
            bad_code <= (k == 0) ? 3'h0 : 3'h7;
            settle();
            chk_bridge(3'h0, 3'h0);
        end
        @(posedge hclk);
        bad_en <= 1'b0;
        torque_ref_voltage <= 8'd80;
        torque_cmd_voltage <= 8'd80;
        settle();
        chk_bridge(3'h7, 3'h0);
        // Stop while the rotor turns
        @(posedge hclk);
        run_stop_in <= 1'b0;
        torque_ref_voltage <= 8'hFF;
        torque_cmd_voltage <= 8'h00;
        step(1'b1);
        settle();
        chk_bridge(3'h7, 3'h0);
        // Reverse brake, then a backward step ends it
        @(posedge hclk);
        run_stop_in <= 1'b1;
        torque_ref_voltage <= 8'h00;
        torque_cmd_voltage <= 8'hFF;
        settle();
        chk_bridge(SNK[1], SRC[1]);
        step(1'b0);
        settle();
        chk_bridge(3'h7, 3'h0);
        ahb(1'b0, 32'h4, 32'h0, st);
        chk32(st & 32'h78, 32'h78, "reverse status");
        test_done();
    end
endmodule : tb
`default_nettype wire
